// ===== dv/two_wire_sensor_slave_port_tb.sv
// testbench joining master and device ends, software traffic over axi4-lite
// assumes the package, interface and both design ends are compiled before it
`timescale 1ns/10ps
module two_wire_sensor_slave_port_tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr, dev_ptr;  // axi addresses, device pointer
  logic [31:0] wdata, rdata, st;        // axi data, status copy
  logic [1:0] bresp, rresp, pin;        // responses, address select
  logic tmode, alert_on, alert_hi, wr_stb, alert_clear, gcall_reset, dev_oe;
  logic [15:0] rd_word, wr_word;        // register traffic at the device
  logic [15:0] regs[16];                // register file behind the pointer
  int fails, check_count, n_clr, n_gc;  // counters
  tws_if bus_if();
  tws_device #(.TIMEOUT_CYC(2000)) u_tws_device (.aclk(aclk), .aresetn(aresetn), .bus(bus_if),
    .address_select_pin(pin), .threshold_or_window_select(tmode), .alert_active(alert_on),
    .alert_is_high(alert_hi), .rd_word(rd_word), .ptr(dev_ptr), .wr_stb(wr_stb), .wr_word(wr_word),
    .alert_clear(alert_clear), .gcall_reset(gcall_reset), .sda_oe(dev_oe));
  // the master's divided clock runs far above the stuck-bus rate
  tws_master #(.HALF_CYC(4)) u_tws_master (.aclk(aclk), .aresetn(aresetn), .bus(bus_if), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  tws_link_monitor #(.TIMEOUT_CYC(2000)) u_mon (.aclk(aclk), .aresetn(aresetn), .scl_oe_m(bus_if.scl_oe_m),
    .sda_oe_m(bus_if.sda_oe_m), .sda_oe_d(bus_if.sda_oe_d), .sda_oe_x(bus_if.sda_oe_x),
    .scl_oe_x(bus_if.scl_oe_x), .scl(bus_if.scl), .sda(bus_if.sda));
  assign rd_word = regs[dev_ptr[3:0]];
  // register file and pulse counters on the device's user side
  always @(posedge aclk) begin
    if (wr_stb) regs[dev_ptr[3:0]] <= wr_word;
    if (alert_clear === 1'b1) n_clr++;
    if (gcall_reset === 1'b1) n_gc++;
  end
  initial begin
    aclk = 0;
    forever #2 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one write: address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
    end while (bvalid !== 1'b1);
    bready <= 0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
    end while (rvalid !== 1'b1);
    d = rdata;
    rready <= 0;
  endtask
  task automatic start_op(input logic [6:0] adr, input logic [1:0] op, input logic [7:0] p, input logic [15:0] w);
    axi_wr(tws_pkg::OFS_ADDR, {25'h0, adr});
    axi_wr(tws_pkg::OFS_PTR, {24'h0, p});
    axi_wr(tws_pkg::OFS_WDATA, {16'h0, w});
    axi_wr(tws_pkg::OFS_CTRL, {29'h0, op, 1'b1});
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do begin axi_rd(tws_pkg::OFS_STAT, st); n++; end while (st[0] !== 1'b0 && n < 3000);
    if (n >= 3000) fails++;
  endtask
  task automatic op(input logic [6:0] adr, input logic [1:0] o, input logic [7:0] p, input logic [15:0] w);
    start_op(adr, o, p, w);
    wait_idle();
  endtask
  // word write, pointer-only write, then two reads through the same pointer
  task automatic t_word;
    logic [31:0] r;
    op({tws_pkg::ADDR_STEM, pin}, tws_pkg::OP_WRITE, 8'h03, 16'hA5C3);
    chk({31'h0, st[1]}, 32'h0);
    chk({24'h0, dev_ptr}, 32'h0000_0003);
    chk({16'h0, regs[3]}, 32'h0000_A5C3);
    op({tws_pkg::ADDR_STEM, pin}, tws_pkg::OP_PTR, 8'h03, 16'h0000);
    for (int i = 0; i < 2; i++) begin
      op({tws_pkg::ADDR_STEM, pin}, tws_pkg::OP_READ, 8'h00, 16'h0000);
      axi_rd(tws_pkg::OFS_RDATA, r);
      chk({16'h0, r[15:0]}, 32'h0000_A5C3);
    end
    $display("word test done");
  endtask
  // each strap answers its own address and refuses the neighbour
  task automatic t_addr;
    for (int a = 0; a < 4; a++) begin
      pin <= a[1:0];
      op({tws_pkg::ADDR_STEM, a[1:0]}, tws_pkg::OP_PTR, {6'h0, a[1:0]}, 16'h0000);
      chk({31'h0, st[1]}, 32'h0);
      chk({24'h0, dev_ptr}, {30'h0, a[1:0]});
      op({tws_pkg::ADDR_STEM, a[1:0] ^ 2'h1}, tws_pkg::OP_PTR, 8'h09, 16'h0000);
      chk({31'h0, st[1]}, 32'h1);
    end
    $display("address test done");
  endtask
  // alert response in window mode for both causes, ignored in threshold mode
  task automatic t_alert;
    logic [31:0] r;
    int c;
    alert_on <= 1;
    for (int h = 1; h >= 0; h--) begin
      alert_hi <= h[0];
      c = n_clr;
      op(tws_pkg::ALERT_RESP_ADDR, tws_pkg::OP_ALERT, 8'h00, 16'h0000);
      axi_rd(tws_pkg::OFS_RDATA, r);
      chk({24'h0, r[7:0]}, {24'h0, tws_pkg::ADDR_STEM, pin, h[0]});
      chk(n_clr - c, 32'h1);
    end
    // a lower-addressed responder pulls data low through the returned byte
    c = n_clr;
    fork
      op(tws_pkg::ALERT_RESP_ADDR, tws_pkg::OP_ALERT, 8'h00, 16'h0000);
      begin
        @(posedge bus_if.sda_oe_d);
        @(negedge bus_if.sda_oe_d);
        @(posedge aclk);
        bus_if.sda_oe_x <= 1;
        repeat (8) @(negedge bus_if.scl);
        @(posedge aclk);
        bus_if.sda_oe_x <= 0;
      end
    join
    chk(n_clr - c, 32'h0);
    tmode <= 1;
    c = n_clr;
    op(tws_pkg::ALERT_RESP_ADDR, tws_pkg::OP_ALERT, 8'h00, 16'h0000);
    chk({31'h0, st[1]}, 32'h1);
    chk(n_clr - c, 32'h0);
    tmode <= 0;
    alert_on <= 0;
    $display("alert test done");
  endtask
  // general call with the reset code restores the pointer
  task automatic t_gcall;
    op({tws_pkg::ADDR_STEM, pin}, tws_pkg::OP_PTR, 8'h07, 16'h0000);
    op(tws_pkg::GCALL_ADDR, tws_pkg::OP_PTR, tws_pkg::GCALL_RESET, 16'h0000);
    chk(n_gc, 32'h1);
    chk({24'h0, dev_ptr}, {24'h0, tws_pkg::PTR_RESET});
    $display("general call test done");
  endtask
  // clock held low while the device drives data; port must let go, then recover
  task automatic t_timeout;
    logic [31:0] r;
    int n;
    op({tws_pkg::ADDR_STEM, pin}, tws_pkg::OP_WRITE, 8'h03, 16'h1234);
    start_op({tws_pkg::ADDR_STEM, pin}, tws_pkg::OP_READ, 8'h00, 16'h0000);
    n = 0;
    while (!(bus_if.sda_oe_d === 1'b1 && bus_if.scl === 1'b0) && n < 2000) begin @(posedge aclk); n++; end
    if (n >= 2000) fails++;
    bus_if.scl_oe_x <= 1;
    repeat (2100) @(posedge aclk);
    chk({31'h0, bus_if.sda_oe_d}, 32'h0);
    bus_if.scl_oe_x <= 0;
    wait_idle();
    op({tws_pkg::ADDR_STEM, pin}, tws_pkg::OP_READ, 8'h00, 16'h0000);
    axi_rd(tws_pkg::OFS_RDATA, r);
    chk({16'h0, r[15:0]}, 32'h0000_1234);
    $display("timeout test done");
  endtask
  initial begin
    aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    awaddr = 0; araddr = 0; wdata = 0; pin = 0; tmode = 0; alert_on = 0; alert_hi = 0;
    bus_if.sda_oe_x = 0; bus_if.scl_oe_x = 0;
    fails = 0; check_count = 0; n_clr = 0; n_gc = 0;
    for (int i = 0; i < 16; i++) regs[i] = 16'h0000;
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    t_word();
    t_addr();
    t_alert();
    t_gcall();
    t_timeout();
    summarize();
  end
  // watchdog: the whole run needs well under this span
  initial begin
    #400000;
    fails++;
    summarize();
  end
endmodule // two_wire_sensor_slave_port_tb

// ===== dv/tws_link_monitor.sv
// checker of the two-wire link between the device end and the master end
// assumes the interface signals arrive as plain inputs, sampled on aclk
`timescale 1ns/10ps
module tws_link_monitor #(
  parameter longint TIMEOUT_CYC = tws_pkg::TIMEOUT_CYC  // stuck-bus limit in cycles
) (
  input wire logic aclk,     // system clock
  input wire logic aresetn,  // synchronous reset, active low
  input wire logic scl_oe_m, // master pulls clock low
  input wire logic sda_oe_m, // master pulls data low
  input wire logic sda_oe_d, // device pulls data low
  input wire logic sda_oe_x, // other slaves pull data low
  input wire logic scl_oe_x, // other slaves stretch clock
  input wire logic scl,      // resolved clock
  input wire logic sda       // resolved data
);
  longint stuck_q;  // cycles of clock low while the device holds data
  longint stuck_d;  // next count
  assign stuck_d = (scl || !sda_oe_d) ? 64'h0 : stuck_q + 64'h1;
  // count only while the bus is stuck with data held by the device
  always_ff @(posedge aclk) begin
    if (!aresetn) stuck_q <= 64'h0;
    else stuck_q <= stuck_d;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_start; $fell(sda) && scl; endsequence  // start condition
  sequence s_stop; $rose(sda) && scl; endsequence   // stop condition
  property p_dev_chg_low; $changed(sda_oe_d) |-> !scl; endproperty
  property p_ack_hold; $rose(scl) && sda_oe_d |-> sda_oe_d[*3]; endproperty
  property p_start_free; s_start |-> !sda_oe_d; endproperty
  property p_stop_quiet; s_stop |-> !sda_oe_d[*4]; endproperty
  property p_start_clk; s_start |-> ##[1:40] !scl; endproperty
  property p_scl_high; $rose(scl) |-> scl[*3]; endproperty
  property p_scl_low; $fell(scl) |-> !scl[*3]; endproperty
  property p_timeout; stuck_q <= TIMEOUT_CYC + 8; endproperty
  a_dev_chg_low: assert property (p_dev_chg_low) else $error("device data changed while clock high");
  a_ack_hold: assert property (p_ack_hold) else $error("device let go of data during clock high");
  a_start_free: assert property (p_start_free) else $error("device held data at start");
  a_stop_quiet: assert property (p_stop_quiet) else $error("device drove data after stop");
  a_start_clk: assert property (p_start_clk) else $error("no clock after start");
  a_scl_high: assert property (p_scl_high) else $error("clock high phase too short");
  a_scl_low: assert property (p_scl_low) else $error("clock low phase too short");
  a_timeout: assert property (p_timeout) else $error("device held data past the stuck-bus limit");
endmodule // tws_link_monitor

// ===== inc/tws_if.sv
// open-drain two-wire link joining the device end and the master end
// assumes each end drives enables only; the wire is low when any enable is high
`timescale 1ns/10ps
interface tws_if;
  logic scl_oe_m;   // master pulls clock low
  logic sda_oe_m;   // master pulls data low
  logic sda_oe_d;   // device pulls data low
  logic sda_oe_x;   // other slaves pull data low
  logic scl_oe_x;   // other slaves stretch clock
  logic scl;        // resolved clock level
  logic sda;        // resolved data level
  assign scl = ~(scl_oe_m | scl_oe_x);
  assign sda = ~(sda_oe_m | sda_oe_d | sda_oe_x);
  modport dev (input scl, input sda, output sda_oe_d);
  modport mst (input scl, input sda, output scl_oe_m, output sda_oe_m);
endinterface

// ===== inc/tws_pkg.sv
// package of constants shared by both ends of the two-wire sensor link
// assumes a 250 MHz system clock on both ends and an open-drain bus resolved by the interface
package tws_pkg;
  localparam int          CLK_HZ          = 250_000_000;      // system clock rate
  localparam int          TIMEOUT_MS      = 35;               // stuck-bus time
  localparam longint      TIMEOUT_CYC     = longint'(CLK_HZ) / 1000 * TIMEOUT_MS; // cycles, rounded down
  localparam int          SCL_MAX_HZ      = 400_000;          // fastest link clock
  localparam int          SCL_HALF_CYC    = (CLK_HZ + 2 * SCL_MAX_HZ - 1) / (2 * SCL_MAX_HZ); // least half period
  localparam logic [4:0]  ADDR_STEM       = 5'h12;            // upper five address bits 10010
  localparam logic [6:0]  ALERT_RESP_ADDR = 7'h0C;            // alert response address
  localparam logic [6:0]  GCALL_ADDR      = 7'h00;            // general call address
  localparam logic [7:0]  GCALL_RESET     = 8'h06;            // general call reset code
  localparam logic [7:0]  PTR_RESET       = 8'h00;            // pointer reset value
  localparam int          NREG            = 16;               // register slots behind the pointer
  // host register offsets on the axi4-lite side
  localparam logic [7:0]  OFS_CTRL        = 8'h00;            // go, two-bit operation code
  localparam logic [7:0]  OFS_STAT        = 8'h04;            // busy, nack, done
  localparam logic [7:0]  OFS_PTR         = 8'h08;            // pointer byte to send
  localparam logic [7:0]  OFS_WDATA       = 8'h0C;            // word to write
  localparam logic [7:0]  OFS_RDATA       = 8'h10;            // word read back
  localparam logic [7:0]  OFS_ADDR        = 8'h14;            // seven-bit target address
  localparam logic [1:0]  OP_WRITE        = 2'h0;             // pointer plus word
  localparam logic [1:0]  OP_PTR          = 2'h1;             // pointer only
  localparam logic [1:0]  OP_READ         = 2'h2;             // word read
  localparam logic [1:0]  OP_ALERT        = 2'h3;             // alert response read
endpackage

// ===== rtl/tws_device.sv
// device end: two-wire slave port with pointer, word access, alert response, general call, timeout
// assumes scl and sda arrive asynchronously and are synchronised here
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
module tws_device #(
  parameter longint TIMEOUT_CYC = tws_pkg::TIMEOUT_CYC  // stuck-bus limit in cycles
) (
  input  wire logic        aclk,           // system clock
  input  wire logic        aresetn,        // synchronous reset, active low
  tws_if.dev               bus,            // two-wire link
  input  wire logic [1:0]  address_select_pin, // address select strap
  input  wire logic        threshold_or_window_select, // high = threshold mode
  input  wire logic        alert_active,   // alert condition present
  input  wire logic        alert_is_high,  // alert from upper limit
  input  wire logic [15:0] rd_word,        // word of the selected register
  output logic [7:0]       ptr,            // register-select pointer
  output logic             wr_stb,         // one-cycle word write strobe
  output logic [15:0]      wr_word,        // word written
  output logic             alert_clear,    // one-cycle alert clear pulse
  output logic             gcall_reset,    // one-cycle register restore pulse
  output logic             sda_oe          // data line pulled low
);
  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001, ST_ADDR = 7'b0000010, ST_RXB = 7'b0000100,
    ST_TXB = 7'b0001000, ST_AACK = 7'b0010000, ST_WAIT = 7'b0100000, ST_GCMD = 7'b1000000
  } tws_state_type;
  logic [2:0] scl_s_q, sda_s_q;     // synchronisers plus history
  logic [1:0] sel_s1_q, sel_s2_q;   // address strap synchroniser
  tws_state_type st_q;              // bus state
  logic [3:0]  bit_q;               // bit counter, ack at 8
  logic [7:0]  sh_q;                // shift register
  logic [1:0]  byte_q;              // byte index within transfer
  logic        rd_q;                // read direction
  logic        alrt_q;              // alert response transfer
  logic        lost_q;              // lost arbitration
  logic [7:0]  hi_q;                // held upper byte
  logic [7:0]  ptr_q;               // pointer
  logic [15:0] wr_word_q;           // written word
  logic        wr_stb_q, aclr_q, gres_q, oe_q; // output flops
  logic [31:0] to_q;                // timeout counter
  logic        in_xfer_q;           // between start and stop
  wire scl_r   = scl_s_q[1] & ~scl_s_q[2];   // clock rising
  wire scl_f   = ~scl_s_q[1] & scl_s_q[2];   // clock falling
  wire start_c = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[1] & sda_s_q[2];
  wire stop_c  = scl_s_q[1] & scl_s_q[2] & sda_s_q[1] & ~sda_s_q[2];
  wire [6:0] my_addr = {tws_pkg::ADDR_STEM, sel_s2_q};
  wire [7:0] alrt_byte = {my_addr, alert_is_high};
  wire [7:0] rx_byte = {sh_q[6:0], sda_s_q[1]};
  wire stuck = in_xfer_q & (~scl_s_q[1] | oe_q);
  wire tmo   = stuck & (to_q >= 32'(TIMEOUT_CYC));
  assign ptr = ptr_q; assign wr_stb = wr_stb_q; assign wr_word = wr_word_q;
  assign alert_clear = aclr_q; assign gcall_reset = gres_q; assign sda_oe = oe_q;
  assign bus.sda_oe_d = oe_q;       // only data is driven, never the clock
  // synchronise both pins through two flops, third flop is edge history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_s_q <= 3'h7; sda_s_q <= 3'h7;
      sel_s1_q <= 2'h0; sel_s2_q <= 2'h0;
    end else begin
      scl_s_q <= {scl_s_q[1:0], bus.scl}; sda_s_q <= {sda_s_q[1:0], bus.sda};
      sel_s1_q <= address_select_pin; sel_s2_q <= sel_s1_q;
    end
  end
  // timeout counter runs while the bus is stuck inside a transfer
  always_ff @(posedge aclk) begin
    if (!aresetn || !stuck || tmo) to_q <= 32'h0000_0000;
    else to_q <= to_q + 32'h0000_0001;
  end
  // main protocol engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_IDLE; bit_q <= 4'h0; sh_q <= 8'h00; byte_q <= 2'h0; rd_q <= 1'b0;
      alrt_q <= 1'b0; lost_q <= 1'b0; hi_q <= 8'h00; ptr_q <= tws_pkg::PTR_RESET;
      wr_word_q <= 16'h0000; wr_stb_q <= 1'b0; aclr_q <= 1'b0; gres_q <= 1'b0;
      oe_q <= 1'b0; in_xfer_q <= 1'b0;
    end else begin
      wr_stb_q <= 1'b0; aclr_q <= 1'b0; gres_q <= 1'b0;
      if (gres_q) ptr_q <= tws_pkg::PTR_RESET;
      if (tmo) begin
        st_q <= ST_IDLE; oe_q <= 1'b0; in_xfer_q <= 1'b0;
      end else if (start_c) begin
        st_q <= ST_ADDR; bit_q <= 4'h0; oe_q <= 1'b0; in_xfer_q <= 1'b1;
      end else if (stop_c) begin
        st_q <= ST_IDLE; oe_q <= 1'b0; in_xfer_q <= 1'b0;
      end else begin
        case (st_q)
          ST_IDLE, ST_WAIT: oe_q <= 1'b0;
          ST_ADDR, ST_RXB, ST_GCMD: begin
            if (scl_r && bit_q < 4'h8) begin
              sh_q <= rx_byte; bit_q <= bit_q + 4'h1;            // sample on rising clock
            end else if (scl_f && bit_q == 4'h8) begin
              bit_q <= 4'h9;
              if (st_q == ST_ADDR) begin
                rd_q <= sh_q[0]; byte_q <= 2'h0; alrt_q <= 1'b0; lost_q <= 1'b0;
                if (sh_q[7:1] == my_addr) oe_q <= 1'b1;
                else if (sh_q[7:1] == tws_pkg::ALERT_RESP_ADDR && sh_q[0] && alert_active
                         && !threshold_or_window_select) begin
                  oe_q <= 1'b1; alrt_q <= 1'b1;
                end else if (sh_q == {tws_pkg::GCALL_ADDR, 1'b0}) oe_q <= 1'b1;
                else st_q <= ST_WAIT;
              end else if (st_q == ST_GCMD) begin
                oe_q <= 1'b1;
                if (sh_q == tws_pkg::GCALL_RESET) gres_q <= 1'b1;
              end else begin
                oe_q <= 1'b1;                                    // ack every byte
                if (byte_q == 2'h0) ptr_q <= sh_q;
                else if (byte_q == 2'h1) hi_q <= sh_q;
                else begin
                  wr_word_q <= {hi_q, sh_q}; wr_stb_q <= 1'b1;
                end
                byte_q <= (byte_q == 2'h2) ? 2'h1 : byte_q + 2'h1;
              end
            end else if (scl_f && bit_q == 4'h9) begin
              oe_q <= 1'b0; bit_q <= 4'h0;
              if (st_q == ST_ADDR && (rd_q || alrt_q)) begin
                st_q <= ST_TXB;
                sh_q <= alrt_q ? alrt_byte : rd_word[15:8];
                oe_q <= alrt_q ? ~alrt_byte[7] : ~rd_word[15];
                byte_q <= 2'h1;
              end else if (st_q == ST_ADDR && sh_q == {tws_pkg::GCALL_ADDR, 1'b0}) st_q <= ST_GCMD;
              else if (st_q == ST_ADDR) st_q <= ST_RXB;
            end
          end
          ST_TXB: begin
            if (scl_r && bit_q < 4'h8) begin
              if (!oe_q && !sda_s_q[1] && !lost_q) begin
                lost_q <= 1'b1;                                  // another slave pulled low
              end
              bit_q <= bit_q + 4'h1;
            end else if (scl_f && bit_q < 4'h8) begin
              sh_q <= {sh_q[6:0], 1'b0};
              oe_q <= lost_q ? 1'b0 : ~sh_q[6];
            end else if (scl_f && bit_q == 4'h8) begin
              oe_q <= 1'b0;                                      // release for master ack
              if (lost_q) st_q <= ST_WAIT;
            end else if (scl_r && bit_q == 4'h8) begin
              bit_q <= 4'h9;
              if (alrt_q) aclr_q <= 1'b1;                        // winner clears alert
              if (sda_s_q[1] || alrt_q) st_q <= ST_WAIT;
            end else if (scl_f && bit_q == 4'h9) begin
              bit_q <= 4'h0;
              sh_q <= (byte_q == 2'h1) ? rd_word[7:0] : rd_word[15:8];
              oe_q <= (byte_q == 2'h1) ? ~rd_word[7] : ~rd_word[15];
              byte_q <= (byte_q == 2'h1) ? 2'h2 : 2'h1;
            end
          end
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // tws_device

// ===== rtl/tws_master.sv
// master end: two-wire controller driven by software over axi4-lite
// assumes a slave end on the link; the clock is divided from aclk and driven out
`timescale 1ns/10ps
module tws_master #(
  parameter int HALF_CYC = tws_pkg::SCL_HALF_CYC  // link phase step in cycles, a quarter of the clock period
) (
  input  wire logic        aclk,     // system clock
  input  wire logic        aresetn,  // synchronous reset, active low
  tws_if.mst               bus,      // two-wire link
  input  wire logic [7:0]  awaddr,   // write address
  input  wire logic        awvalid,  // write address valid
  output logic             awready,  // write address ready
  input  wire logic [31:0] wdata,    // write data
  input  wire logic [3:0]  wstrb,    // write strobes
  input  wire logic        wvalid,   // write data valid
  output logic             wready,   // write data ready
  output logic [1:0]       bresp,    // write response
  output logic             bvalid,   // write response valid
  input  wire logic        bready,   // write response ready
  input  wire logic [7:0]  araddr,   // read address
  input  wire logic        arvalid,  // read address valid
  output logic             arready,  // read address ready
  output logic [31:0]      rdata,    // read data
  output logic [1:0]       rresp,    // read response
  output logic             rvalid,   // read response valid
  input  wire logic        rready    // read response ready
);
  logic aw_q, w_q, bv_q, rv_q;            // channel state
  logic [7:0] awa_q; logic [31:0] wd_q, rd_q;
  logic [6:0] addr_q; logic [7:0] ptrb_q; logic [15:0] wword_q, rword_q;
  logic [1:0] op_q; logic go_q, busy_q, nack_q, done_q;
  logic [1:0] sda_s_q;                    // data synchroniser
  logic [15:0] div_q; logic [7:0] ph_q;   // clock divider and phase step
  logic [5:0] seq_q;                      // bit slot within transfer
  logic scl_oe_q, sda_oe_q;
  wire wr_go = aw_q & w_q & ~bv_q;
  wire tick = (div_q == 16'(HALF_CYC - 1));
  // axi4-lite write: capture address and data independently, respond once both held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0; w_q <= 1'b0; bv_q <= 1'b0; awa_q <= 8'h00; wd_q <= 32'h0000_0000;
      addr_q <= {tws_pkg::ADDR_STEM, 2'h0}; ptrb_q <= 8'h00; wword_q <= 16'h0000; op_q <= 2'h0; go_q <= 1'b0;
    end else begin
      go_q <= 1'b0;
      if (awvalid && !aw_q) begin aw_q <= 1'b1; awa_q <= awaddr; end
      if (wvalid && !w_q) begin w_q <= 1'b1; wd_q <= wdata; end
      if (bv_q && bready) bv_q <= 1'b0;
      if (wr_go) begin
        aw_q <= 1'b0; w_q <= 1'b0; bv_q <= 1'b1;
        case (awa_q)
          tws_pkg::OFS_CTRL: if (wd_q[0] && !busy_q) begin go_q <= 1'b1; op_q <= wd_q[2:1]; end
          tws_pkg::OFS_PTR: ptrb_q <= wd_q[7:0];
          tws_pkg::OFS_WDATA: wword_q <= wd_q[15:0];
          tws_pkg::OFS_ADDR: addr_q <= wd_q[6:0];
          default: ;
        endcase
      end
    end
  end
  assign awready = ~aw_q; assign wready = ~w_q; assign bvalid = bv_q; assign bresp = 2'h0;
  // axi4-lite read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin rv_q <= 1'b0; rd_q <= 32'h0000_0000; end
    else if (rv_q) begin if (rready) rv_q <= 1'b0; end
    else if (arvalid) begin
      rv_q <= 1'b1;
      case (araddr)
        tws_pkg::OFS_STAT: rd_q <= {29'h0, done_q, nack_q, busy_q};
        tws_pkg::OFS_PTR: rd_q <= {24'h0, ptrb_q};
        tws_pkg::OFS_WDATA: rd_q <= {16'h0, wword_q};
        tws_pkg::OFS_RDATA: rd_q <= {16'h0, rword_q};
        tws_pkg::OFS_ADDR: rd_q <= {25'h0, addr_q};
        default: rd_q <= 32'h0000_0000;
      endcase
    end
  end
  assign arready = ~rv_q; assign rvalid = rv_q; assign rdata = rd_q; assign rresp = 2'h0;
  // link engine: four phases per bit; seq counts byte bits incl. ack
  wire [7:0] abyte = (op_q == tws_pkg::OP_ALERT) ? {tws_pkg::ALERT_RESP_ADDR, 1'b1}
                   : {addr_q, op_q == tws_pkg::OP_READ};
  wire rdop = (op_q == tws_pkg::OP_READ) | (op_q == tws_pkg::OP_ALERT);
  wire [1:0] nbytes = (op_q == tws_pkg::OP_WRITE) ? 2'h3 : (op_q == tws_pkg::OP_PTR) ? 2'h1
                    : (op_q == tws_pkg::OP_READ) ? 2'h2 : 2'h1;
  logic [1:0] bi_q;                      // byte index after address
  wire [3:0] bitn = 4'(seq_q % 9);
  wire [7:0] txb = (bi_q == 2'h0) ? ptrb_q : (bi_q == 2'h1) ? wword_q[15:8] : wword_q[7:0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sda_s_q <= 2'h3; div_q <= 16'h0000; ph_q <= 8'h00; seq_q <= 6'h00; bi_q <= 2'h0;
      scl_oe_q <= 1'b0; sda_oe_q <= 1'b0; busy_q <= 1'b0; nack_q <= 1'b0; done_q <= 1'b0;
      rword_q <= 16'h0000;
    end else begin
      sda_s_q <= {sda_s_q[0], bus.sda};
      div_q <= (tick || !busy_q) ? 16'h0000 : div_q + 16'h0001;
      if (go_q) begin
        busy_q <= 1'b1; done_q <= 1'b0; nack_q <= 1'b0; ph_q <= 8'h00; seq_q <= 6'h00;
        bi_q <= 2'h0; sda_oe_q <= 1'b1;                    // start: data falls, clock high
      end else if (busy_q && tick) begin
        ph_q <= ph_q + 8'h01;
        case (ph_q[1:0])
          2'h0: scl_oe_q <= 1'b1;                          // clock low
          2'h1: begin                                      // set data while low
            if (ph_q[7:2] == 6'h3F) sda_oe_q <= 1'b1;
            else if (bitn == 4'h8) sda_oe_q <= (seq_q > 6'h08 && rdop && bi_q + 2'h1 != nbytes); // nack last
            else if (seq_q < 6'h09) sda_oe_q <= ~abyte[7 - 3'(bitn)];
            else if (rdop) sda_oe_q <= 1'b0;
            else sda_oe_q <= ~txb[7 - 3'(bitn)];
          end
          2'h2: begin
            scl_oe_q <= 1'b0;                              // clock high, sample
            if (bitn == 4'h8 && (seq_q == 6'h08 || !rdop) && sda_s_q[1]) nack_q <= 1'b1;
            // no shift during the stop sequence, the word is already complete
            if (ph_q[7:2] != 6'h3F && bitn != 4'h8 && seq_q > 6'h08 && rdop) rword_q <= {rword_q[14:0], sda_s_q[1]};
          end
          default: begin
            seq_q <= seq_q + 6'h01;
            if (bitn == 4'h8 && seq_q > 6'h08) bi_q <= bi_q + 2'h1;
            if (bitn == 4'h8 && (nack_q || (seq_q > 6'h08 && bi_q + 2'h1 == nbytes) ||
                (seq_q == 6'h08 && nbytes == 2'h0))) ph_q <= 8'hFC;  // go to stop
            if (ph_q == 8'hFF) begin busy_q <= 1'b0; done_q <= 1'b1; sda_oe_q <= 1'b0; end
          end
        endcase
      end
    end
  end
  assign bus.scl_oe_m = scl_oe_q; assign bus.sda_oe_m = sda_oe_q;
endmodule // tws_master
